// ---- rtl/rcs_pkg.sv ----
// Package for the reset cause and status block.
// Assumes one 40 MHz clock and a classic Wishbone register bus.
package rcs_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] OFF_RCC = 4'h0;
	localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
	localparam logic [3:0] OFF_IRQ_EN = 4'h8;
	localparam logic [3:0] OFF_IRQ_CLR = 4'hC;
	localparam int unsigned B_TRAP = 15;
	localparam int unsigned B_ILLOP = 14;
	localparam int unsigned B_VREGSF = 11;
	localparam int unsigned B_CM = 9;
	localparam int unsigned B_VSTBY = 8;
	localparam int unsigned B_EXTERNAL_PIN_RESET_FLAG = 7;
	localparam int unsigned B_SWR = 6;
	localparam int unsigned B_SWDT = 5;
	localparam int unsigned B_WATCHDOG_TIMEOUT_FLAG = 4;
	localparam int unsigned B_SLEEP = 3;
	localparam int unsigned B_IDLE = 2;
	localparam int unsigned B_BOR = 1;
	localparam int unsigned B_POR = 0;
	localparam logic [15:0] RCC_IMPL = 16'hCBFF;
	localparam logic [15:0] RCC_RESET = 16'h0000;
	localparam logic [15:0] RCC_POR_SET = 16'h0003;
	localparam logic [15:0] RCC_BOR_SET = 16'h0002;
	localparam int unsigned N_EV = 9;
	localparam logic [8:0] IRQ_RESET = 9'h000;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// ---- rtl/rcs_sync.sv ----
// Two-flop synchroniser for a vector of levels from outside the clock.
// Assumes the inputs are slow levels; each bit is caught independently.
`timescale 1ns/1ps
module rcs_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
		end
	end
	assign q_o = s2_r;
endmodule // rcs_sync

// ---- rtl/rcs_edge.sv ----
// Rising edge detector producing one-cycle event pulses.
// Assumes inputs are already synchronous to clk_i.
`timescale 1ns/1ps
module rcs_edge #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] lvl_i,
	output logic [W-1:0] rise_o
);
	logic [W-1:0] prev_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_r <= '0;
		end else begin
			prev_r <= lvl_i;
		end
	end
	assign rise_o = lvl_i & ~prev_r;
endmodule // rcs_edge

// ---- rtl/rcs_top.sv ----
// Reset cause register with watchdog and regulator controls.
// Assumes event inputs are levels from other logic or pins, and that
// a power-on or brown-out event lands while rst_i is released.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps

// What this block does
// - Trap conflict reset sets bit 15, held until software clears it.
// - Configuration mismatch reset sets bit 9.
// - Bit 8 high keeps the regulator active in sleep; low lets it stand by.
// - Master-clear pin reset sets bit 7.
// - Reset instruction sets bit 6.
// - Bit 5 enables the watchdog; an unprogrammed fuse forces it on.
// - Watchdog time-out sets bit 4.
// - Software may set or clear any flag but bit 14, which stays set while illegal_op_i is high; writes never cause resets.
module rcs_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic trap_conflict_i,
	input wire logic illegal_op_i,
	input wire logic config_mismatch_i,
	input wire logic master_clear_pin_i,
	input wire logic reset_instr_i,
	input wire logic watchdog_timeout_i,
	input wire logic wake_sleep_i,
	input wire logic wake_idle_i,
	input wire logic power_on_i,
	input wire logic brownout_i,
	input wire logic watchdog_fuse_enable_i,
	input wire logic sleeping_i,
	output logic watchdog_enable_o,
	output logic regulator_standby_o,
	output logic irq_o
);
	logic [15:0] rcc_r, rcc_nxt;
	logic [8:0] ien_r, ien_nxt;
	logic [8:0] ist_r, ist_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic ack_r, ack_nxt;
	logic wdt_r, wdt_nxt;
	logic vstby_r, vstby_nxt;
	logic irq_r, irq_nxt;
	logic [1:0] pin_s;
	logic [8:0] lvl;
	logic [8:0] ev;
	logic [15:0] set_v;
	logic req, wr, rd;
	logic [3:0] off;

	// Pin-level inputs are synchronised before use.
	rcs_sync #(.W(2)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({master_clear_pin_i, watchdog_fuse_enable_i}),
		.q_o(pin_s)
	);

	assign lvl = {trap_conflict_i, config_mismatch_i, pin_s[1],
		reset_instr_i, watchdog_timeout_i, wake_sleep_i, wake_idle_i,
		power_on_i, brownout_i};

	rcs_edge #(.W(9)) u_edge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.lvl_i(lvl),
		.rise_o(ev)
	);

	function automatic logic [15:0] wmask(input logic [3:0] sel);
		wmask = {{8{sel[1]}}, {8{sel[0]}}};
	endfunction

	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr = req && wb_we_i;
	assign rd = req && !wb_we_i;
	assign off = wb_adr_i[3:0];

	always_comb begin
		set_v = 16'h0000;
		set_v[rcs_pkg::B_TRAP] = ev[8];
		set_v[rcs_pkg::B_CM] = ev[7];
		set_v[rcs_pkg::B_EXTERNAL_PIN_RESET_FLAG] = ev[6];
		set_v[rcs_pkg::B_SWR] = ev[5];
		set_v[rcs_pkg::B_WATCHDOG_TIMEOUT_FLAG] = ev[4];
		set_v[rcs_pkg::B_SLEEP] = ev[3];
		set_v[rcs_pkg::B_IDLE] = ev[2];
		set_v[rcs_pkg::B_ILLOP] = illegal_op_i;
		if (ev[1]) begin
			set_v = set_v | rcs_pkg::RCC_POR_SET;
		end
		if (ev[0]) begin
			set_v = set_v | rcs_pkg::RCC_BOR_SET;
		end
	end

	always_comb begin
		rcc_nxt = rcc_r;
		ien_nxt = ien_r;
		ist_nxt = ist_r;
		ack_nxt = req;
		dat_nxt = rcs_pkg::RD_ZERO;
		// A write only stores bits; no reset is ever requested here.
		if (wr && off == rcs_pkg::OFF_RCC) begin
			rcc_nxt = (rcc_r & ~wmask(wb_sel_i)) |
				(wb_dat_i[15:0] & wmask(wb_sel_i));
		end
		if (wr && off == rcs_pkg::OFF_IRQ_EN && wb_sel_i[0]) begin
			ien_nxt = {wb_sel_i[1] ? wb_dat_i[8] : ien_r[8],
				wb_dat_i[7:0]};
		end
		if (wr && off == rcs_pkg::OFF_IRQ_CLR) begin
			ist_nxt = ist_r & ~wb_dat_i[8:0];
		end
		// Hardware sets win over a same-cycle software clear.
		rcc_nxt = (rcc_nxt | set_v) & rcs_pkg::RCC_IMPL;
		ist_nxt = ist_nxt | ev;
		if (rd) begin
			unique case (off)
				rcs_pkg::OFF_RCC: dat_nxt = {16'h0000, rcc_r};
				rcs_pkg::OFF_IRQ_STAT: dat_nxt = {23'h00_0000, ist_r};
				rcs_pkg::OFF_IRQ_EN: dat_nxt = {23'h00_0000, ien_r};
				default: dat_nxt = rcs_pkg::RD_ZERO;
			endcase
		end
		wdt_nxt = rcc_nxt[rcs_pkg::B_SWDT] | pin_s[0];
		vstby_nxt = sleeping_i & ~rcc_nxt[rcs_pkg::B_VSTBY];
		irq_nxt = |(ist_nxt & ien_nxt);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rcc_r <= rcs_pkg::RCC_RESET;
			ien_r <= rcs_pkg::IRQ_RESET;
			ist_r <= rcs_pkg::IRQ_RESET;
			dat_r <= rcs_pkg::RD_ZERO;
			ack_r <= 1'b0;
			wdt_r <= 1'b0;
			vstby_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			rcc_r <= rcc_nxt;
			ien_r <= ien_nxt;
			ist_r <= ist_nxt;
			dat_r <= dat_nxt;
			ack_r <= ack_nxt;
			wdt_r <= wdt_nxt;
			vstby_r <= vstby_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;
	assign watchdog_enable_o = wdt_r;
	assign regulator_standby_o = vstby_r;
	assign irq_o = irq_r;

	trap_sets_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ev[8] |=> rcc_r[rcs_pkg::B_TRAP])
		else $error("trap flag not set");

	cm_sets_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ev[7] |=> rcc_r[rcs_pkg::B_CM])
		else $error("mismatch flag not set");

	vreg_ctrl_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		regulator_standby_o |-> !$past(rcc_r[rcs_pkg::B_VSTBY])
		|| $past(wr))
		else $error("regulator standby while keep-active set");

	pin_sets_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$rose(pin_s[1]) |=> rcc_r[rcs_pkg::B_EXTERNAL_PIN_RESET_FLAG])
		else $error("pin reset flag not set");

	swr_sets_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ev[5] |=> rcc_r[rcs_pkg::B_SWR])
		else $error("software reset flag not set");

	wdt_fuse_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		pin_s[0] |=> watchdog_enable_o)
		else $error("fuse did not force watchdog");

	watchdog_timeout_flag_sets_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ev[4] |=> rcc_r[rcs_pkg::B_WATCHDOG_TIMEOUT_FLAG])
		else $error("timeout flag not set");

	sw_write_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr && off == rcs_pkg::OFF_RCC && wb_sel_i == 4'hF && set_v == 0
		|=> rcc_r == ($past(wb_dat_i[15:0]) & rcs_pkg::RCC_IMPL))
		else $error("software write not stored");

	por_sets_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ev[1] |=> rcc_r[1:0] == 2'b11)
		else $error("power-on flags not set");

	unimpl_zero_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(rcc_r & ~rcs_pkg::RCC_IMPL) == 16'h0000)
		else $error("unimplemented bit set");

	ack_once_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	sleep_sets_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ev[3] |=> rcc_r[rcs_pkg::B_SLEEP])
		else $error("sleep flag not set");

	idle_sets_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ev[2] |=> rcc_r[rcs_pkg::B_IDLE])
		else $error("idle flag not set");

	bor_sets_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ev[0] |=> rcc_r[rcs_pkg::B_BOR])
		else $error("brown-out flag not set");

	illop_sets_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		illegal_op_i |=> rcc_r[rcs_pkg::B_ILLOP])
		else $error("illegal operation flag not set");

	ack_follow_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		req |=> wb_ack_o)
		else $error("request not acknowledged");

	ack_cause_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> $past(req))
		else $error("ack without request");

	irq_match_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		irq_o == |(ist_r & ien_r))
		else $error("interrupt level wrong");

	wdt_match_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		watchdog_enable_o == (rcc_r[rcs_pkg::B_SWDT] || $past(pin_s[0])))
		else $error("watchdog enable wrong");

	stby_src_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		regulator_standby_o |-> $past(sleeping_i))
		else $error("standby while awake");

	stat_sets_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ev != 9'h000 |=> (ist_r & $past(ev)) == $past(ev))
		else $error("status bit not set");

	stat_clr_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr && off == rcs_pkg::OFF_IRQ_CLR && ev == 9'h000
		|=> (ist_r & $past(wb_dat_i[8:0])) == 9'h000)
		else $error("status bit not cleared");

	en_write_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr && off == rcs_pkg::OFF_IRQ_EN && wb_sel_i[1:0] == 2'b11
		|=> ien_r == $past(wb_dat_i[8:0]))
		else $error("enable write not stored");

	en_hold_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!(wr && off == rcs_pkg::OFF_IRQ_EN) |=> $stable(ien_r))
		else $error("enable changed without write");

	stat_keep_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!(wr && off == rcs_pkg::OFF_IRQ_CLR)
		|=> (ist_r & $past(ist_r)) == $past(ist_r))
		else $error("status bit lost without clear");

	rd_rcc_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd && off == rcs_pkg::OFF_RCC
		|=> wb_dat_o == {16'h0000, $past(rcc_r)})
		else $error("cause register read wrong");

	rd_stat_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd && off == rcs_pkg::OFF_IRQ_STAT
		|=> wb_dat_o == {23'h00_0000, $past(ist_r)})
		else $error("status read wrong");

	rd_clr_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd && off == rcs_pkg::OFF_IRQ_CLR
		|=> wb_dat_o == 32'h0000_0000)
		else $error("clear register read not zero");

	dat_idle_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");

	rcc_hold_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!wr && set_v == 16'h0000 |=> $stable(rcc_r))
		else $error("cause register changed without cause");

	trap_keep_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rcc_r[rcs_pkg::B_TRAP] && !(wr && off == rcs_pkg::OFF_RCC)
		|=> rcc_r[rcs_pkg::B_TRAP])
		else $error("trap flag lost without write");

	wr_cov: cover property (@(posedge clk_i) disable iff (rst_i) wr);
	rd_cov: cover property (@(posedge clk_i) disable iff (rst_i) rd);
	irq_cov: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
	por_cov: cover property (@(posedge clk_i) disable iff (rst_i) ev[1]);
endmodule // rcs_top

// ---- verif/reset_cause_status_bench.sv ----
// Self-checking bench for the reset cause and status block.
// Assumes the rtl files are compiled first; it drives every port itself.
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module reset_cause_status_bench;
	logic clk_i = 0;
	logic rst_i = 1;
	logic wb_we_i = 0;
	logic wb_cyc_i = 0;
	logic wb_stb_i = 0;
	logic [31:0] wb_adr_i = '0;
	logic [31:0] wb_dat_i = '0;
	logic [31:0] wb_dat_o;
	logic [3:0] wb_sel_i = '0;
	logic [8:0] ev = '0;
	logic illegal_op_i = 0;
	logic fuse_i = 0;
	logic sleeping_i = 0;
	logic wb_ack_o;
	logic watchdog_enable_o;
	logic regulator_standby_o;
	logic irq_o;
	int err_total = 0;
	int cmp_count = 0;
	logic [31:0] exp_q[$];
	logic [31:0] exp_v;
	logic [15:0] d;
	logic [15:0] rb [9] = '{16'h0002, 16'h0003, 16'h0004, 16'h0008,
		16'h0010, 16'h0040, 16'h0080, 16'h0200, 16'h8000};
	rcs_top DUT (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
		.wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
		.trap_conflict_i(ev[8]), .illegal_op_i, .config_mismatch_i(ev[7]),
		.master_clear_pin_i(ev[6]), .reset_instr_i(ev[5]),
		.watchdog_timeout_i(ev[4]), .wake_sleep_i(ev[3]),
		.wake_idle_i(ev[2]), .power_on_i(ev[1]), .brownout_i(ev[0]),
		.watchdog_fuse_enable_i(fuse_i), .sleeping_i, .watchdog_enable_o,
		.regulator_standby_o, .irq_o);
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	// Single classic cycle; reads queue their expected data for the monitor.
	task automatic bus(input logic [3:0] a, input logic w,
		input logic [3:0] s, input logic [15:0] v, input logic [15:0] e);
		if (!w) exp_q.push_back({16'h0000, e});
		wb_adr_i <= {28'h000_0000, a};
		wb_we_i <= w;
		wb_sel_i <= s;
		wb_dat_i <= {16'h0000, v};
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && !wb_we_i) begin
			exp_v = exp_q.pop_front();
			`CHK("read data", exp_v, wb_dat_o)
		end
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#(25 * 6000);
		err_total++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'h9599_565f));
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		bus(4'h0, 0, 4'h3, 16'h0000, 16'h0000);
		for (int i = 0; i < 9; i++) begin
			bus(4'h0, 1, 4'h3, 16'h0000, 16'h0000);
			bus(4'h8, 1, 4'h3, 16'h0001 << i, 16'h0000);
			ev[i] <= 1;
			repeat (6) @(posedge clk_i);
			ev[i] <= 0;
			bus(4'h0, 0, 4'h3, 16'h0000, rb[i]);
			bus(4'h4, 0, 4'h3, 16'h0000, 16'h0001 << i);
			`CHK("irq", 1'b1, irq_o)
			bus(4'hC, 1, 4'h1, 16'h01FF, 16'h0000);
			@(posedge clk_i);
			`CHK("irq", 1'b0, irq_o)
		end
		illegal_op_i <= 1;
		bus(4'h0, 1, 4'h3, 16'h0000, 16'h0000);
		bus(4'h0, 0, 4'h3, 16'h0000, 16'h4000);
		illegal_op_i <= 0;
		bus(4'h0, 1, 4'h3, 16'h0000, 16'h0000);
		bus(4'h0, 0, 4'h3, 16'h0000, 16'h0000);
		bus(4'h0, 1, 4'h2, 16'hFFFF, 16'h0000);
		bus(4'h0, 0, 4'h3, 16'h0000, 16'hCB00);
		repeat (4) begin
			d = 16'($urandom);
			bus(4'h0, 1, 4'h3, d, 16'h0000);
			bus(4'h0, 0, 4'h3, 16'h0000, d & 16'hCBFF);
			@(posedge clk_i);
			`CHK("wdt enable", d[5], watchdog_enable_o)
		end
		bus(4'h4, 1, 4'h1, 16'h01FF, 16'h0000);
		bus(4'h4, 0, 4'h3, 16'h0000, 16'h0000);
		bus(4'h2, 1, 4'h3, 16'hFFFF, 16'h0000);
		bus(4'h2, 0, 4'h3, 16'h0000, 16'h0000);
		bus(4'h0, 1, 4'h3, 16'h0000, 16'h0000);
		sleeping_i <= 1;
		fuse_i <= 1;
		repeat (5) @(posedge clk_i);
		`CHK("wdt enable", 1'b1, watchdog_enable_o)
		`CHK("standby", 1'b1, regulator_standby_o)
		bus(4'h0, 1, 4'h3, 16'h0100, 16'h0000);
		@(posedge clk_i);
		`CHK("standby", 1'b0, regulator_standby_o)
		repeat (4) @(posedge clk_i);
		give_verdict();
	end
endmodule // reset_cause_status_bench
